// *** rtl/ldg_pkg.sv ***
package ldg_pkg;

	// ========================================================
	// Widths
	localparam int LAMP_W  = 12;
	localparam int DIM_W   = 21;
	localparam int LEVEL_W = 8;
	localparam int TIMER_W = 17;

	// ========================================================
	// Counts and steps
	localparam int          FAULT_CYCLES = 65536;
	localparam logic [11:0] DUTY_STEP    = 12'h004;
	localparam logic [11:0] SOFT_STEP    = 12'h002;
	localparam logic [11:0] DEAD_CYC     = 12'h00a;

	// ========================================================
	// Reset values
	localparam logic [11:0] ON_TIME_RST = 12'h000;
	localparam logic [11:0] SOFT_RST    = 12'h000;

	// ========================================================
	// Controller states
	typedef enum logic [1:0] {
		ST_LOCK,
		ST_STRIKE,
		ST_RUN,
		ST_FAULT
	} ldg_state_type;

endpackage

// *** rtl/ldg_period_gen.sv ***
`timescale 1ns/100ps

// ============================================================
// Free-running period counter with registered wrap pulse
module ldg_period_gen
	import ldg_pkg::*;
#(
	parameter int W = 12
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic [W-1:0] period,
	input  wire logic         restart,
	output logic      [W-1:0] count_q,
	output logic              wrap_q
);

	logic last;

	assign last = (count_q + W'(1) >= period) || (period <= W'(1));

	always_ff @(posedge clock) begin
		if (reset) begin
			count_q <= '0;
		end else if (restart || last) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wrap_q <= 1'b0;
		end else begin
			wrap_q <= last && !restart;
		end
	end

endmodule // ldg_period_gen

// *** rtl/ldg_cycle_timer.sv ***
`timescale 1ns/100ps

// ============================================================
// Saturating event counter that flags a limit
module ldg_cycle_timer
	import ldg_pkg::*;
#(
	parameter int LIMIT = 65536
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic clear,
	input  wire logic step,
	output logic      expired_q
);

	logic [TIMER_W-1:0] count_q;
	logic               at_limit;

	assign at_limit = (count_q >= TIMER_W'(LIMIT));

	always_ff @(posedge clock) begin
		if (reset || clear) begin
			count_q <= '0;
		end else if (step && !at_limit) begin
			count_q <= count_q + TIMER_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset || clear) begin
			expired_q <= 1'b0;
		end else begin
			expired_q <= at_limit;
		end
	end

endmodule // ldg_cycle_timer

// *** rtl/ldg_lamp_ctrl.sv ***
`timescale 1ns/100ps

module ldg_lamp_ctrl
	import ldg_pkg::*;
#(
	parameter int FAULT_LAMP_CYCLES = FAULT_CYCLES
) (
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic [LAMP_W-1:0]  lamp_osc_resistor,
	input  wire logic [DIM_W-1:0]   dim_osc_period,
	input  wire logic               dim_osc_or_pulse_input,
	input  wire logic [LEVEL_W-1:0] analog_dim_level,
	input  wire logic               brightness_source_select,
	input  wire logic               dim_polarity_select,
	input  wire logic               lamp_current_sense,
	input  wire logic               lamp_current_present,
	input  wire logic               lamp_overcurrent,
	input  wire logic               overvoltage_sense,
	input  wire logic               inverter_overvoltage_monitor,
	input  wire logic               inverter_undervoltage_monitor,
	input  wire logic               core_supply_lockout,
	output logic                    first_switch_drive,
	output logic                    second_switch_drive,
	output logic                    burst_dim_modulation,
	output logic                    strike_active,
	output logic                    lamp_running,
	output logic                    fault_active
);

	// ========================================================
	// Declarations
	ldg_state_type       state_q;
	ldg_state_type       state_d;
	logic                supply_ok;
	logic                drive_en;
	logic                burst_prev_q;
	logic                burst_start;
	logic                burst_d;
	logic [LAMP_W-1:0]   lamp_period;
	logic [LAMP_W+1:0]   boost_prod;
	logic [LAMP_W-1:0]   lamp_cnt;
	logic                lamp_wrap;
	logic [LAMP_W-1:0]   half;
	logic [LAMP_W-1:0]   max_on;
	logic [LAMP_W-1:0]   on_time_q;
	logic [LAMP_W-1:0]   soft_lim_q;
	logic [LAMP_W-1:0]   on_eff;
	logic [DIM_W-1:0]    dim_cnt;
	logic [LEVEL_W-1:0]  level_eff;
	logic [DIM_W+8:0]    dim_prod;
	logic [DIM_W+1:0]    dim_thresh;
	logic                strike_exp;
	logic                out_exp;
	logic                gate_a_d;
	logic                gate_b_d;

	// ========================================================
	// Supply monitoring
	// The undervoltage monitor reads healthy high and the overvoltage monitor healthy low
	assign supply_ok = !core_supply_lockout
		&& inverter_undervoltage_monitor
		&& !inverter_overvoltage_monitor;

	// ========================================================
	// Lamp oscillator
	assign boost_prod = {2'b00, lamp_osc_resistor} * 14'(3);
	assign lamp_period = (state_q == ST_STRIKE)
		? boost_prod[LAMP_W+1:2]
		: lamp_osc_resistor;

	ldg_period_gen #(
		.W (LAMP_W)
	) u_lamp_osc (
		.clock   (clock),
		.reset   (reset),
		.period  (lamp_period),
		.restart (burst_start),
		.count_q (lamp_cnt),
		.wrap_q  (lamp_wrap)
	);

	// ========================================================
	// Dimming oscillator and burst modulation
	ldg_period_gen #(
		.W (DIM_W)
	) u_dim_osc (
		.clock   (clock),
		.reset   (reset),
		.period  (dim_osc_period),
		.restart (1'b0),
		.count_q (dim_cnt),
		.wrap_q  ()
	);

	assign level_eff = dim_polarity_select
		? ~analog_dim_level
		: analog_dim_level;
	assign dim_prod = dim_osc_period * ({1'b0, level_eff} + 9'h001);
	assign dim_thresh = dim_prod[DIM_W+8:8];
	assign burst_d = brightness_source_select
		? dim_osc_or_pulse_input
		: ({1'b0, dim_cnt} < dim_thresh);

	always_ff @(posedge clock) begin
		if (reset) begin
			burst_dim_modulation <= 1'b0;
			burst_prev_q         <= 1'b0;
		end else begin
			burst_dim_modulation <= burst_d;
			burst_prev_q         <= burst_dim_modulation;
		end
	end
	assign burst_start = burst_dim_modulation && !burst_prev_q;

	// ========================================================
	// Strike and lamp-out timers, counted in lamp cycles
	ldg_cycle_timer #(
		.LIMIT (FAULT_LAMP_CYCLES)
	) u_strike_tmr (
		.clock     (clock),
		.reset     (reset),
		.clear     (state_q != ST_STRIKE),
		.step      (lamp_wrap && burst_dim_modulation),
		.expired_q (strike_exp)
	);

	ldg_cycle_timer #(
		.LIMIT (FAULT_LAMP_CYCLES)
	) u_out_tmr (
		.clock     (clock),
		.reset     (reset),
		.clear     (state_q != ST_RUN || lamp_current_present),
		.step      (lamp_wrap && burst_dim_modulation),
		.expired_q (out_exp)
	);

	// ========================================================
	// Controller state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_LOCK: begin
				if (supply_ok) begin
					state_d = ST_STRIKE;
				end
			end
			ST_STRIKE: begin
				if (!supply_ok) begin
					state_d = ST_LOCK;
				end else if (lamp_overcurrent) begin
					state_d = ST_FAULT;
				end else if (overvoltage_sense || strike_exp) begin
					state_d = ST_FAULT;
				end else if (lamp_current_present
						&& burst_dim_modulation) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!supply_ok) begin
					state_d = ST_LOCK;
				end else if (lamp_overcurrent) begin
					state_d = ST_FAULT;
				end else if (out_exp) begin
					state_d = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (!supply_ok) begin
					state_d = ST_LOCK;
				end
			end
			default: begin
				state_d = ST_LOCK;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= ST_LOCK;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			strike_active <= 1'b0;
			lamp_running  <= 1'b0;
			fault_active  <= 1'b0;
		end else begin
			strike_active <= (state_d == ST_STRIKE);
			lamp_running  <= (state_d == ST_RUN);
			fault_active  <= (state_d == ST_FAULT);
		end
	end

	// ========================================================
	// On-time regulation and soft-start
	assign drive_en = burst_dim_modulation
		&& (state_d == ST_STRIKE || state_d == ST_RUN);
	assign half   = lamp_period >> 1;
	assign max_on = (half > DEAD_CYC) ? half - DEAD_CYC : '0;
	assign on_eff = (on_time_q < soft_lim_q) ? on_time_q : soft_lim_q;
	always_ff @(posedge clock) begin
		if (reset || burst_start || !drive_en) begin
			soft_lim_q <= SOFT_RST;
		end else if (lamp_wrap && soft_lim_q < max_on) begin
			soft_lim_q <= soft_lim_q + SOFT_STEP;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || !drive_en) begin
			on_time_q <= ON_TIME_RST;
		end else if (lamp_wrap) begin
			if (lamp_current_sense) begin
				if (on_time_q >= DUTY_STEP) begin
					on_time_q <= on_time_q - DUTY_STEP;
				end
			end else if (!overvoltage_sense
					&& on_time_q + DUTY_STEP <= max_on) begin
				on_time_q <= on_time_q + DUTY_STEP;
			end
		end
	end

	// ========================================================
	// Gate outputs
	assign gate_a_d = drive_en && (lamp_cnt < on_eff);
	assign gate_b_d = drive_en && (lamp_cnt >= half)
		&& (lamp_cnt - half < on_eff);

	always_ff @(posedge clock) begin
		if (reset) begin
			first_switch_drive  <= 1'b0;
			second_switch_drive <= 1'b0;
		end else begin
			first_switch_drive  <= gate_a_d;
			second_switch_drive <= gate_b_d;
		end
	end

	// ========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	gates_exclusive_a: assert property (
		!(first_switch_drive && second_switch_drive))
		else $error("both gates on together");
	second_half_a: assert property (
		$rose(second_switch_drive) |-> $past(lamp_cnt) >= $past(half))
		else $error("second gate rose in first half");
	dim_low_off_a: assert property (
		!burst_dim_modulation |=> !first_switch_drive
			&& !second_switch_drive)
		else $error("gate on during dimming low phase");
	pulse_direct_a: assert property (
		brightness_source_select |=>
			burst_dim_modulation == $past(dim_osc_or_pulse_input))
		else $error("pulse input not passed to dimming");
	full_level_a: assert property (
		!brightness_source_select && !dim_polarity_select
			&& analog_dim_level == 8'hff && dim_osc_period > 21'h000001
			|=> burst_dim_modulation)
		else $error("full analog level not full burst");
	strike_boost_a: assert property (
		state_q == ST_STRIKE && $past(state_q, 2) == ST_STRIKE
			&& $past(state_q) == ST_STRIKE && lamp_wrap
			|-> {$past(lamp_cnt), 2'b00} + 14'h004
			<= 14'h003 * {2'b00, lamp_osc_resistor}
			&& {$past(lamp_cnt), 2'b00} + 14'h008
			> 14'h003 * {2'b00, lamp_osc_resistor})
		else $error("strike period not boosted");
	run_period_a: assert property (
		state_q == ST_RUN && $past(state_q) == ST_RUN && lamp_wrap
			|-> $past(lamp_cnt) == lamp_osc_resistor - 12'h001)
		else $error("run period not normal");
	supply_trip_a: assert property (
		!supply_ok |=> state_q == ST_LOCK ##1 !first_switch_drive
			&& !second_switch_drive)
		else $error("supply trip did not stop drive");
	overcurrent_a: assert property (
		supply_ok && lamp_overcurrent && (state_q == ST_RUN
			|| state_q == ST_STRIKE) |=> fault_active
			&& !first_switch_drive && !second_switch_drive)
		else $error("overcurrent did not fault");
	lamp_out_a: assert property (
		supply_ok && !lamp_overcurrent && out_exp
			&& state_q == ST_RUN |=> state_q == ST_FAULT)
		else $error("lamp out timeout missed");
	fault_hold_a: assert property (
		state_q == ST_FAULT && supply_ok |=> state_q == ST_FAULT)
		else $error("fault left while supplies good");
	soft_start_a: assert property (
		burst_start |=> soft_lim_q == SOFT_RST)
		else $error("soft-start not restarted");
	regulate_down_a: assert property (
		drive_en && lamp_wrap && lamp_current_sense
			&& on_time_q >= DUTY_STEP
			|=> on_time_q == $past(on_time_q) - DUTY_STEP)
		else $error("on-time not reduced");
	disabled_off_a: assert property (
		state_q == ST_FAULT || state_q == ST_LOCK
			|-> !first_switch_drive && !second_switch_drive)
		else $error("gate on while drive disabled");
	run_reached_c: cover property (state_q == ST_STRIKE
		##1 state_q == ST_RUN);
	fault_reached_c: cover property ($rose(fault_active));
	strike_timeout_c: cover property (state_q == ST_STRIKE && strike_exp);
	pulse_burst_c: cover property (brightness_source_select
		&& $rose(burst_dim_modulation));

endmodule // ldg_lamp_ctrl

// *** test/ldg_lamp_load.sv ***
`timescale 1ns/100ps

// ============================================================
// Switches, transformer and lamp as seen from the gate pins
module ldg_lamp_load
	import ldg_pkg::*;
#(
	parameter int SENSE_ON = 200
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic first_switch_drive,
	input  wire logic second_switch_drive,
	input  wire logic lamp_lit,
	output logic      lamp_current_sense,
	output logic      lamp_current_present
);
	logic [11:0] on_q;

	// ========================================================
	// Current flows after a gate pulse into a lit lamp
	always_ff @(posedge clock) begin
		if (reset || !lamp_lit) begin
			on_q                 <= 12'h000;
			lamp_current_present <= 1'b0;
			lamp_current_sense   <= 1'b0;
		end else if (first_switch_drive || second_switch_drive) begin
			on_q                 <= on_q + 12'h001;
			lamp_current_present <= 1'b1;
			lamp_current_sense   <= (on_q >= SENSE_ON);
		end else begin
			on_q <= 12'h000;
		end
	end
endmodule // ldg_lamp_load

// *** test/lamp_burst_dimming_gate_controller_tb.sv ***
`timescale 1ns/100ps

module lamp_burst_dimming_gate_controller_tb;
	import ldg_pkg::*;

	logic               clock, reset, pin, sel, pol, oc, uvm, lock, lit, ovm;
	logic [LEVEL_W-1:0] lvl;
	logic [DIM_W-1:0]   dper;
	logic               sense, present, ga, gb, burst, strk, run, flt;
	int                 err_total, samples_checked, c, b, w, w1, h;

	ldg_lamp_ctrl #(.FAULT_LAMP_CYCLES(8)) ldg_lamp_ctrl_i (
		.clock(clock), .reset(reset), .lamp_osc_resistor(12'h4e4),
		.dim_osc_period(dper), .dim_osc_or_pulse_input(pin),
		.analog_dim_level(lvl), .brightness_source_select(sel),
		.dim_polarity_select(pol), .lamp_current_sense(sense),
		.lamp_current_present(present), .lamp_overcurrent(oc),
		.overvoltage_sense(1'b0), .inverter_overvoltage_monitor(ovm),
		.inverter_undervoltage_monitor(uvm), .core_supply_lockout(lock),
		.first_switch_drive(ga), .second_switch_drive(gb),
		.burst_dim_modulation(burst), .strike_active(strk),
		.lamp_running(run), .fault_active(flt));

	ldg_lamp_load ldg_lamp_load_i (
		.clock(clock), .reset(reset), .first_switch_drive(ga),
		.second_switch_drive(gb), .lamp_lit(lit),
		.lamp_current_sense(sense), .lamp_current_present(present));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ========================================================
	// Helpers
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return ga;
			1: return strk;
			2: return run;
			default: return flt;
		endcase
	endfunction

	task automatic wait_sig(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(negedge clock);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			$display("unexpected timeout waiting on signal %0d", s);
			finish_test();
		end
	endtask

	// Lamp period, gate B cycles inside it and gate A width
	task automatic lamp_period();
		wait_sig(0, 1'b0, 3000);
		wait_sig(0, 1'b1, 3000);
		c = 0;
		b = 0;
		while (ga === 1'b1 && c < 3000) begin
			@(negedge clock);
			c++;
		end
		w = c;
		while (ga !== 1'b1 && c < 3000) begin
			b += gb;
			@(negedge clock);
			c++;
		end
		if (c >= 3000) begin
			err_total++;
			$display("unexpected timeout measuring lamp period");
			finish_test();
		end
	endtask

	task automatic quiet(input int n);
		h = 0;
		repeat (n) begin
			@(negedge clock);
			h += (ga | gb);
		end
	endtask

	always @(negedge clock) begin
		if (!reset && ga === 1'b1 && gb === 1'b1) begin
			check("gate overlap", 1, 0);
		end
	end

	// ========================================================
	// Scenarios
	task automatic t_lockout();
		quiet(2000);
		check("gates in lockout", h, 0);
		check("strike in lockout", strk, 0);
		lock = 1'b0;
		wait_sig(1, 1'b1, 4);
		$display("test lockout done");
	endtask

	task automatic t_strike();
		repeat (2) lamp_period();
		check("strike period", c, 939);
		check("gate B in period", b > 0, 1);
		wait_sig(3, 1'b1, 12 * 939);
		@(negedge clock);
		check("gates in fault", ga | gb, 0);
		quiet(2000);
		check("fault holds", {flt, h[7:0]}, 9'h100);
		uvm = 1'b0;
		@(negedge clock);
		check("fault left", flt, 0);
		quiet(500);
		check("monitor trip drive", {strk, h[7:0]}, 9'h000);
		uvm = 1'b1;
		wait_sig(1, 1'b1, 4);
		$display("test strike done");
	endtask

	task automatic t_run();
		lit = 1'b1;
		wait_sig(2, 1'b1, 20000);
		lamp_period();
		check("run period", c, 1252);
		lit = 1'b0;
		wait_sig(3, 1'b1, 12 * 1252);
		@(negedge clock);
		check("lamp out", {run, ga | gb}, 0);
		{lit, uvm} = 2'b10;
		@(negedge clock);
		uvm = 1'b1;
		wait_sig(2, 1'b1, 20000);
		$display("test run done");
	endtask

	task automatic t_pulse();
		pin = 1'b0;
		repeat (2) @(negedge clock);
		check("burst low", {burst, ga, gb}, 3'h0);
		pol = 1'b1;
		lvl = 8'h00;
		quiet(3000);
		check("gates in low phase", {burst, h[7:0]}, 9'h000);
		pin = 1'b1;
		@(negedge clock);
		check("burst high", burst, 1);
		lamp_period();
		w1 = w;
		repeat (8) lamp_period();
		check("soft start", w1 < w, 1);
		$display("test pulse done");
	endtask

	task automatic t_analog();
		logic [8:0] lv [4] = '{9'h07f, 9'h180, 9'h0ff, 9'h1ff};
		int         ex [4] = '{512, 512, 1024, 4};
		dper = 21'h000400;
		sel = 1'b0;
		foreach (ex[i]) begin
			{pol, lvl} = lv[i];
			repeat (4) @(negedge clock);
			h = 0;
			repeat (1024) begin
				@(negedge clock);
				h += burst;
			end
			check("analog duty", h, ex[i]);
		end
		$display("test analog done");
	endtask

	task automatic t_fault();
		sel = 1'b1;
		lamp_period();
		oc = 1'b1;
		@(negedge clock);
		check("overcurrent", {flt, ga, gb}, 3'h4);
		oc = 1'b0;
		lock = 1'b1;
		@(negedge clock);
		check("lockout ends fault", flt, 0);
		quiet(1000);
		check("lockout blocks", {strk, h[7:0]}, 9'h000);
		{lock, ovm} = 2'b01;
		quiet(300);
		check("over monitor trip", {strk, h[7:0]}, 9'h000);
		ovm = 1'b0;
		wait_sig(1, 1'b1, 4);
		$display("test fault done");
	endtask

	initial begin
		{reset, pin, sel, pol, oc, uvm, lock, lit} = 8'hf6;
		lvl = 8'hff;
		ovm = 1'b0;
		dper = 21'h000400;
		err_total = 0;
		samples_checked = 0;
		repeat (16) @(negedge clock);
		reset = 1'b0;
		t_lockout();
		t_strike();
		t_run();
		t_pulse();
		t_analog();
		t_fault();
		finish_test();
	end
endmodule // lamp_burst_dimming_gate_controller_tb
